// [rtl/omc_pkg.sv]
// package: mode encodings, sequence states and EPROM size codes for the operating mode controller
package omc_pkg;
  // operating modes, one-hot
  typedef enum logic [2:0] {
    OMC_RUN     = 3'h1,
    OMC_MONITOR = 3'h2,
    OMC_PROGRAM = 3'h4
  } omc_mode_t;

  // 2-bit mode field encoding used by selector and start-up setting
  localparam logic [1:0] OMC_SEL_RUN = 2'h0;
  localparam logic [1:0] OMC_SEL_MONITOR = 2'h1;
  localparam logic [1:0] OMC_SEL_PROGRAM = 2'h2;

  // controller sequence states
  typedef enum logic [3:0] {
    OMC_ST_RESET = 4'h1,
    OMC_ST_BOOT  = 4'h2,
    OMC_ST_DECIDE = 4'h4,
    OMC_ST_OPER  = 4'h8
  } omc_state_t;

  // cassette EPROM size codes
  localparam logic [1:0] OMC_EPROM_8K = 2'h0;
  localparam logic [1:0] OMC_EPROM_16K = 2'h1;
  localparam logic [1:0] OMC_EPROM_32K = 2'h3;

  localparam logic [2:0] OMC_MODE_RESET = 3'h1;
endpackage

// [rtl/omc_mode_ctrl.sv]
// operating mode controller: start-up mode decision, mode changes, permissions, cassette status
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
module omc_mode_ctrl (
  input wire logic MCLK,
  input wire logic RSTN,
  // peripheral presence and console selector (pins)
  input wire logic CONSOLE_PRESENT,
  input wire logic OTHER_PERIPH_PRESENT,
  input wire logic [1:0] CONSOLE_SELECTOR,
  input wire logic PASSWORD_OK,
  // stored start-up setting, same clock
  input wire logic [1:0] STARTUP_MODE_SETTING,
  // scan engine, same clock
  input wire logic SCAN_BOUNDARY,
  // configuration switch 2 and cassette pins
  input wire logic AUTOBOOT_SWITCH,
  input wire logic CASSETTE_WP_SWITCH,
  input wire logic [1:0] EPROM_SIZE_SWITCH,
  // copy engine handshake, same clock
  input wire logic BOOT_COPY_DONE,
  // output image from program
  input wire logic [15:0] OUTPUT_BITS,
  output var omc_pkg::omc_mode_t MODE,
  output logic PROGRAM_EXECUTE,
  output logic ONLINE_EDIT_ALLOW,
  output logic FORCE_ALLOW,
  output logic PROGRAM_EDIT_ALLOW,
  output logic BOOT_COPY_START,
  output logic CASSETTE_WRITE_PROTECT_FLAG,
  output logic [1:0] EPROM_SIZE_CODE,
  output logic [15:0] OUTPUT_POINTS
);
  import omc_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [6:0] s1_r, s2_r;
  logic [6:0] s_in;
  assign s_in = {EPROM_SIZE_SWITCH, CASSETTE_WP_SWITCH, AUTOBOOT_SWITCH, CONSOLE_SELECTOR,
                 CONSOLE_PRESENT};
  // other peripheral kept separate for readability
  logic op1_r, op2_r;
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      s1_r <= 7'h00;
      s2_r <= 7'h00;
      op1_r <= 1'b0;
      op2_r <= 1'b0;
    end else begin
      s1_r <= s_in;
      s2_r <= s1_r;
      op1_r <= OTHER_PERIPH_PRESENT;
      op2_r <= op1_r;
    end
  end
  logic con_p, oth_p, auto_sw, wp_sw;
  logic [1:0] sel, eprom_sw;
  assign con_p = s2_r[0];
  assign sel = s2_r[2:1];
  assign auto_sw = s2_r[3];
  assign wp_sw = s2_r[4];
  assign eprom_sw = s2_r[6:5];
  assign oth_p = op2_r;

  function automatic omc_mode_t dec_mode(input logic [1:0] code);
    omc_mode_t m;
    m = OMC_RUN;
    if (code == OMC_SEL_MONITOR) begin
      m = OMC_MONITOR;
    end else if (code == OMC_SEL_PROGRAM) begin
      m = OMC_PROGRAM;
    end
    return m;
  endfunction

  // ****************************************************************
  // mode sequence
  // ****************************************************************
  omc_state_t st_r, st_nxt;
  omc_mode_t mode_r, mode_nxt;
  omc_mode_t pend_r, pend_nxt;
  logic con_prev_r, con_prev_nxt;
  logic unlocked_r, unlocked_nxt;
  logic boot_go_r, boot_go_nxt;
  logic [1:0] warm_r, warm_nxt;
  logic settled;
  // synchroniser stages come out of reset empty, so pin copies are stale until both fill
  assign settled = warm_r[1];

  always_comb begin
    warm_nxt = {warm_r[0], 1'b1};
    st_nxt = st_r;
    mode_nxt = mode_r;
    pend_nxt = pend_r;
    con_prev_nxt = con_p;
    unlocked_nxt = unlocked_r;
    boot_go_nxt = 1'b0;
    unique case (st_r)
      OMC_ST_RESET: begin
        // two synchroniser stages settle before the start-up decision
        if (settled) begin
          st_nxt = OMC_ST_BOOT;
          if (auto_sw) begin
            boot_go_nxt = 1'b1;
          end
        end
      end
      OMC_ST_BOOT: begin
        if (!auto_sw || BOOT_COPY_DONE) begin
          st_nxt = OMC_ST_DECIDE;
        end
      end
      OMC_ST_DECIDE: begin
        if (con_p) begin
          pend_nxt = dec_mode(sel);
          unlocked_nxt = 1'b1;
        end else if (oth_p) begin
          pend_nxt = OMC_PROGRAM;
        end else begin
          pend_nxt = dec_mode(STARTUP_MODE_SETTING);
        end
        mode_nxt = pend_nxt;
        st_nxt = OMC_ST_OPER;
      end
      OMC_ST_OPER: begin
        // attachment after power-up keeps the mode until a password unlocks
        if (con_p && !con_prev_r) begin
          unlocked_nxt = 1'b0;
        end
        if (!con_p) begin
          unlocked_nxt = 1'b0;
        end else if (PASSWORD_OK) begin
          unlocked_nxt = 1'b1;
        end
        if (con_p && unlocked_r) begin
          pend_nxt = dec_mode(sel);
        end
        // applying only at a boundary keeps each scan under one mode
        if (SCAN_BOUNDARY) begin
          mode_nxt = pend_r;
        end
      end
      default: begin
        st_nxt = OMC_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      st_r <= OMC_ST_RESET;
      mode_r <= OMC_RUN;
      pend_r <= OMC_RUN;
      con_prev_r <= 1'b0;
      unlocked_r <= 1'b0;
      boot_go_r <= 1'b0;
      warm_r <= 2'h0;
    end else begin
      warm_r <= warm_nxt;
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      pend_r <= pend_nxt;
      con_prev_r <= con_prev_nxt;
      unlocked_r <= unlocked_nxt;
      boot_go_r <= boot_go_nxt;
    end
  end

  // ****************************************************************
  // permissions and outputs
  // ****************************************************************
  logic oper;
  assign oper = (st_r == OMC_ST_OPER);
  // permissions load on the same edge as the mode they belong to
  logic oper_nxt;
  assign oper_nxt = (st_nxt == OMC_ST_OPER);
  logic exec_nxt, edit_nxt, force_nxt, prog_nxt;
  logic [15:0] pts_nxt;
  logic exec_r, edit_r, force_r, prog_r, wp_r;
  logic [1:0] esz_r;
  logic [15:0] pts_r;

  always_comb begin
    exec_nxt = oper_nxt && (mode_nxt != OMC_PROGRAM);
    edit_nxt = oper_nxt && (mode_nxt == OMC_MONITOR);
    force_nxt = oper_nxt && (mode_nxt != OMC_RUN);
    prog_nxt = oper_nxt && (mode_nxt == OMC_PROGRAM);
    pts_nxt = exec_nxt ? OUTPUT_BITS : 16'h0000;
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      exec_r <= 1'b0;
      edit_r <= 1'b0;
      force_r <= 1'b0;
      prog_r <= 1'b0;
      pts_r <= 16'h0000;
      wp_r <= 1'b0;
      esz_r <= OMC_EPROM_8K;
    end else begin
      exec_r <= exec_nxt;
      edit_r <= edit_nxt;
      force_r <= force_nxt;
      prog_r <= prog_nxt;
      pts_r <= pts_nxt;
      wp_r <= wp_sw;
      esz_r <= eprom_sw;
    end
  end

  assign MODE = mode_r;
  assign PROGRAM_EXECUTE = exec_r;
  assign ONLINE_EDIT_ALLOW = edit_r;
  assign FORCE_ALLOW = force_r;
  assign PROGRAM_EDIT_ALLOW = prog_r;
  assign BOOT_COPY_START = boot_go_r;
  assign CASSETTE_WRITE_PROTECT_FLAG = wp_r;
  assign EPROM_SIZE_CODE = esz_r;
  assign OUTPUT_POINTS = pts_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_onehot;
    @(posedge MCLK) disable iff (!RSTN) $onehot(mode_r);
  endproperty
  a_onehot: assert property (p_onehot) else $error("mode not one-hot");

  property p_run_locks;
    @(posedge MCLK) disable iff (!RSTN) (mode_r == OMC_RUN) |-> !edit_r && !force_r;
  endproperty
  a_run_locks: assert property (p_run_locks) else $error("run allows edits");

  property p_mon_exec;
    @(posedge MCLK) disable iff (!RSTN) (mode_r == OMC_MONITOR) |-> exec_r && edit_r && force_r;
  endproperty
  a_mon_exec: assert property (p_mon_exec) else $error("monitor permissions wrong");

  property p_mon_out;
    @(posedge MCLK) disable iff (!RSTN)
      (oper && mode_nxt == OMC_MONITOR) |=> pts_r == $past(OUTPUT_BITS);
  endproperty
  a_mon_out: assert property (p_mon_out) else $error("monitor outputs wrong");

  property p_prog_stop;
    @(posedge MCLK) disable iff (!RSTN) (mode_nxt == OMC_PROGRAM) |=> !exec_r && pts_r == 16'h0000;
  endproperty
  a_prog_stop: assert property (p_prog_stop) else $error("program mode executes");

  property p_decide_other;
    @(posedge MCLK) disable iff (!RSTN)
      (st_r == OMC_ST_DECIDE && !con_p && oth_p) |=> mode_r == OMC_PROGRAM;
  endproperty
  a_decide_other: assert property (p_decide_other) else $error("other periph not program");

  property p_decide_con;
    @(posedge MCLK) disable iff (!RSTN)
      (st_r == OMC_ST_DECIDE && con_p) |=> mode_r == dec_mode($past(sel));
  endproperty
  a_decide_con: assert property (p_decide_con) else $error("console mode not taken");

  property p_decide_none;
    @(posedge MCLK) disable iff (!RSTN)
      (st_r == OMC_ST_DECIDE && !con_p && !oth_p && STARTUP_MODE_SETTING == OMC_SEL_MONITOR)
      |=> mode_r == OMC_MONITOR;
  endproperty
  a_decide_none: assert property (p_decide_none) else $error("start-up setting ignored");

  property p_hot_keep;
    @(posedge MCLK) disable iff (!RSTN) (oper && !unlocked_r) |=> $stable(pend_r);
  endproperty
  a_hot_keep: assert property (p_hot_keep) else $error("locked pending mode moved");

  property p_unlock;
    @(posedge MCLK) disable iff (!RSTN) (oper && con_p && PASSWORD_OK) |=> unlocked_r;
  endproperty
  a_unlock: assert property (p_unlock) else $error("password did not unlock");

  sequence s_boot_pulse;
    boot_go_r ##1 !boot_go_r;
  endsequence

  property p_boot;
    @(posedge MCLK) disable iff (!RSTN)
      (st_r == OMC_ST_RESET && settled && auto_sw) |=> s_boot_pulse;
  endproperty
  a_boot: assert property (p_boot) else $error("autoboot pulse wrong");

  property p_boot_wait;
    @(posedge MCLK) disable iff (!RSTN)
      (st_r == OMC_ST_BOOT && auto_sw && !BOOT_COPY_DONE) |=> st_r == OMC_ST_BOOT;
  endproperty
  a_boot_wait: assert property (p_boot_wait) else $error("left boot before copy done");

  property p_eprom;
    @(posedge MCLK) disable iff (!RSTN) 1'b1 |=> EPROM_SIZE_CODE == $past(eprom_sw);
  endproperty
  a_eprom: assert property (p_eprom) else $error("eprom size code wrong");

  property p_wp;
    @(posedge MCLK) disable iff (!RSTN) wp_sw |=> CASSETTE_WRITE_PROTECT_FLAG;
  endproperty
  a_wp: assert property (p_wp) else $error("write protect flag wrong");

  property p_scan;
    @(posedge MCLK) disable iff (!RSTN) (oper && !SCAN_BOUNDARY) |=> $stable(mode_r);
  endproperty
  a_scan: assert property (p_scan) else $error("mode changed mid scan");
endmodule
`default_nettype wire

// [tb/omc_periph_model.sv]
// far-side model: console or host peripheral, operator, cassette and copy engine
`timescale 1ns/1ps
`default_nettype none
module omc_periph_model (
  input wire logic clk,
  input wire logic copy_start,
  output logic console_present,
  output logic other_present,
  output logic [1:0] selector,
  output logic password_ok,
  output logic copy_done,
  output logic wp_switch,
  output logic [1:0] eprom_switch
);
  import omc_pkg::*;
  int copy_delay = 3;
  int cnt = 0;
  initial begin
    console_present = 1'b0;
    other_present = 1'b0;
    selector = 2'h0;
    password_ok = 1'b0;
    copy_done = 1'b0;
    wp_switch = 1'b0;
    eprom_switch = 2'h0;
  end
  // ****************************************************************
  // operator and cassette actions
  // ****************************************************************
  task automatic attach(input logic c, input logic o);
    @(posedge clk);
    console_present <= c;
    other_present <= o;
    // unplugged selector lines float, so never show the last code
    if (!c) selector <= ~selector;
  endtask
  task automatic turn(input logic [1:0] s);
    @(posedge clk);
    if ((selector ^ s) == 2'h2) begin
      selector <= OMC_SEL_MONITOR;
      @(posedge clk);
    end
    selector <= s;
  endtask
  task automatic give_password();
    @(posedge clk);
    password_ok <= 1'b1;
    @(posedge clk);
    password_ok <= 1'b0;
  endtask
  task automatic cassette(input logic wp, input logic [1:0] e);
    @(posedge clk);
    wp_switch <= wp;
    eprom_switch <= e;
  endtask
  always @(posedge clk) begin
    copy_done <= (cnt == 1);
    if (copy_start === 1'b1) cnt <= copy_delay;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// testbench: start-up mode, hot attach, permissions, output gating, cassette status
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_top;
  import omc_pkg::*;
  logic MCLK = 1'b0;
  logic RSTN = 1'b0;
  logic SCAN_BOUNDARY = 1'b0;
  logic AUTOBOOT_SWITCH = 1'b0;
  logic [1:0] STARTUP_MODE_SETTING = 2'h0;
  logic [15:0] OUTPUT_BITS = 16'h0;
  logic con, oth, pwd, cdone, wp, bstart, exe, onl, frc, edt, wpf, wpv;
  logic [1:0] sel, eps, ecode;
  logic [1:0] etab[3] = '{OMC_EPROM_8K, OMC_EPROM_16K, OMC_EPROM_32K};
  logic [15:0] pts;
  logic [15:0] q[$];
  omc_mode_t mode;
  int compares = 0;
  int n_mismatch = 0;
  int n_boot = 0;
  int seed = 42;
  always #2 MCLK = ~MCLK;
  always @(posedge MCLK) if (bstart === 1'b1) n_boot++;
  omc_mode_ctrl DUT (.MCLK(MCLK), .RSTN(RSTN), .CONSOLE_PRESENT(con),
    .OTHER_PERIPH_PRESENT(oth), .CONSOLE_SELECTOR(sel), .PASSWORD_OK(pwd),
    .STARTUP_MODE_SETTING(STARTUP_MODE_SETTING), .SCAN_BOUNDARY(SCAN_BOUNDARY),
    .AUTOBOOT_SWITCH(AUTOBOOT_SWITCH), .CASSETTE_WP_SWITCH(wp), .EPROM_SIZE_SWITCH(eps),
    .BOOT_COPY_DONE(cdone), .OUTPUT_BITS(OUTPUT_BITS), .MODE(mode), .PROGRAM_EXECUTE(exe),
    .ONLINE_EDIT_ALLOW(onl), .FORCE_ALLOW(frc), .PROGRAM_EDIT_ALLOW(edt),
    .BOOT_COPY_START(bstart), .CASSETTE_WRITE_PROTECT_FLAG(wpf), .EPROM_SIZE_CODE(ecode),
    .OUTPUT_POINTS(pts));
  omc_periph_model P (.clk(MCLK), .copy_start(bstart), .console_present(con),
    .other_present(oth), .selector(sel), .password_ok(pwd), .copy_done(cdone),
    .wp_switch(wp), .eprom_switch(eps));
  // ****************************************************************
  // reference model and shared tasks
  // ****************************************************************
  function automatic omc_mode_t exp_mode(input int code);
    // code 3 reads as run by design choice
    return (code == 1) ? OMC_MONITOR : (code == 2) ? OMC_PROGRAM : OMC_RUN;
  endfunction
  task automatic check_mode(input int code);
    omc_mode_t m;
    m = exp_mode(code);
    @(negedge MCLK);
    `CHK(mode, m)
    `CHK(exe, m != OMC_PROGRAM)
    `CHK(onl, m == OMC_MONITOR)
    `CHK(frc, m != OMC_RUN)
    `CHK(edt, m == OMC_PROGRAM)
  endtask
  task automatic scan();
    repeat (5) @(posedge MCLK);
    SCAN_BOUNDARY <= 1'b1;
    @(posedge MCLK);
    SCAN_BOUNDARY <= 1'b0;
  endtask
  task automatic power_on(input logic c, input logic o, input logic [1:0] s,
                          input logic [1:0] st, input logic ab);
    @(posedge MCLK);
    RSTN <= 1'b0;
    STARTUP_MODE_SETTING <= st;
    AUTOBOOT_SWITCH <= ab;
    P.attach(c, o);
    if (c) P.turn(s);
    repeat (10) @(posedge MCLK);
    n_boot = 0;
    RSTN <= 1'b1;
    repeat (20) @(posedge MCLK);
    `CHK(n_boot, int'(ab))
  endtask
  task automatic out_check(input bit ex);
    logic [15:0] v;
    q.delete();
    repeat (8) begin
      v = 16'($random(seed));
      @(posedge MCLK);
      OUTPUT_BITS <= v;
      q.push_back(v);
      @(negedge MCLK);
      if (q.size() > 1) `CHK(pts, ex ? q[q.size()-2] : 16'h0)
    end
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    for (int st = 0; st < 4; st++) begin
      power_on(1'b0, 1'b0, 2'h0, 2'(st), 1'b0);
      check_mode(st);
    end
    for (int s = 0; s < 4; s++) begin
      power_on(1'b1, 1'b0, 2'(s), OMC_SEL_PROGRAM, 1'b0);
      check_mode(s);
    end
    power_on(1'b0, 1'b1, OMC_SEL_RUN, OMC_SEL_RUN, 1'b1);
    check_mode(2);
    done("power-on");
    power_on(1'b0, 1'b0, OMC_SEL_RUN, OMC_SEL_MONITOR, 1'b0);
    P.attach(1'b0, 1'b1);
    scan();
    check_mode(1);
    P.attach(1'b1, 1'b0);
    P.turn(OMC_SEL_PROGRAM);
    scan();
    check_mode(1);
    P.give_password();
    repeat (6) @(posedge MCLK);
    check_mode(1);
    scan();
    check_mode(2);
    out_check(1'b0);
    P.turn(OMC_SEL_MONITOR);
    scan();
    check_mode(1);
    out_check(1'b1);
    done("hot attach");
    for (int i = 0; i < 6; i++) begin
      wpv = 1'($random(seed));
      P.cassette(wpv, etab[i % 3]);
      repeat (4) @(posedge MCLK);
      @(negedge MCLK);
      `CHK(wpf, wpv)
      `CHK(ecode, etab[i % 3])
    end
    done("cassette");
    give_verdict();
  end
  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire
